// >>> tsi_pkg.sv
// constants, register map and state codes for the temperature sensor slave
// assumes one core clock domain; the two-wire bus pins arrive asynchronously
// Functional notes
// - first written byte is pointer, rest data
// - read without repeated start after a pointer-only write closed by stop zeroes pointer
// - pointer auto-advances across temperature and limit pairs
// - window alert outside low/high limits, polarity
// - critical alert above critical limit, polarity
// - works as plain sensor after power-up
// - pointer starts at temperature high byte
// - temperature read returns high byte first
package tsi_pkg;

  // ***************************************************************
  // bus addressing
  // ***************************************************************
  localparam logic [6:0] TSI_SLAVE_ADDR = 7'h4B;
  localparam logic [3:0] TSI_BITS_BYTE  = 4'h8;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] TSI_REG_TEMP_MSB = 8'h00;
  localparam logic [7:0] TSI_REG_TEMP_LSB = 8'h01;
  localparam logic [7:0] TSI_REG_CONFIG   = 8'h03;
  localparam logic [7:0] TSI_REG_HIGH_MSB = 8'h04;
  localparam logic [7:0] TSI_REG_HIGH_LSB = 8'h05;
  localparam logic [7:0] TSI_REG_LOW_MSB  = 8'h06;
  localparam logic [7:0] TSI_REG_LOW_LSB  = 8'h07;
  localparam logic [7:0] TSI_REG_CRIT_MSB = 8'h08;
  localparam logic [7:0] TSI_REG_CRIT_LSB = 8'h09;

  // configuration fields
  localparam int TSI_CFG_INT_POL  = 0;
  localparam int TSI_CFG_CRIT_POL = 1;

  // ***************************************************************
  // values after reset
  // ***************************************************************
  localparam logic [7:0]  TSI_PTR_RESET    = 8'h00;
  localparam logic [7:0]  TSI_CONFIG_RESET = 8'h00;
  localparam logic [15:0] TSI_HIGH_RESET   = 16'h2000;
  localparam logic [15:0] TSI_LOW_RESET    = 16'h0500;
  localparam logic [15:0] TSI_CRIT_RESET   = 16'h4980;

  // ***************************************************************
  // link states
  // ***************************************************************
  typedef enum logic [2:0] {
    TSI_IDLE     = 3'b000,
    TSI_ADDR     = 3'b001,
    TSI_ACK_ADDR = 3'b010,
    TSI_WRITE    = 3'b011,
    TSI_ACK_WR   = 3'b100,
    TSI_READ     = 3'b101,
    TSI_MACK     = 3'b110
  } tsi_state_t;

endpackage

// >>> tsi_byte_if.sv
// byte-level hand-off between the bus engine and the register file
// assumes both ends run on core_clk; events are one-cycle pulses except restart, which holds until the next start
`timescale 1ns/10ps
interface tsi_byte_if;
  logic       start_evt;
  logic       restart;
  logic       stop_evt;
  logic       addr_hit;
  logic       rw;
  logic       wr_strobe;
  logic [7:0] wr_byte;
  logic       rd_take;
  logic [7:0] rd_data;

  modport link
  (
    output start_evt,
    output restart,
    output stop_evt,
    output addr_hit,
    output rw,
    output wr_strobe,
    output wr_byte,
    output rd_take,
    input  rd_data
  );

  modport regs
  (
    input  start_evt,
    input  restart,
    input  stop_evt,
    input  addr_hit,
    input  rw,
    input  wr_strobe,
    input  wr_byte,
    input  rd_take,
    output rd_data
  );
endinterface

// >>> tsi_i2c_link.sv
// two-wire slave bit engine: synchronises pins, finds start/stop, moves bytes
// assumes scl is slow against core_clk (at least four clocks per phase)
`timescale 1ns/10ps
module tsi_i2c_link
  import tsi_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  tsi_byte_if.link  bus
);

  // ***************************************************************
  // pin synchronisers and edge finding
  // ***************************************************************
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_prev;
  logic       sda_prev;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_sync[1] & ~scl_prev;
  assign scl_fall  = ~scl_sync[1] & scl_prev;
  assign start_det = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_det  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

  // ***************************************************************
  // byte engine
  // ***************************************************************
  tsi_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic       in_frame;
  logic       master_ack;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state         <= TSI_IDLE;
      bit_cnt       <= 4'h0;
      shift         <= 8'h00;
      in_frame      <= 1'b0;
      master_ack    <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe        <= 1'b0;
      bus.start_evt <= 1'b0;
      bus.restart   <= 1'b0;
      bus.stop_evt  <= 1'b0;
      bus.addr_hit  <= 1'b0;
      bus.rw        <= 1'b0;
      bus.wr_strobe <= 1'b0;
      bus.wr_byte   <= 8'h00;
      bus.rd_take   <= 1'b0;
    end
    else
    begin
      bus.start_evt <= 1'b0;
      bus.stop_evt  <= 1'b0;
      bus.addr_hit  <= 1'b0;
      bus.wr_strobe <= 1'b0;
      bus.rd_take   <= 1'b0;
      if (start_det)
      begin
        // a start inside a frame is the repeated start
        bus.start_evt <= 1'b1;
        bus.restart   <= in_frame;
        in_frame      <= 1'b1;
        state         <= TSI_ADDR;
        bit_cnt       <= 4'h0;
        sda_oe        <= 1'b0;
      end
      else if (stop_det)
      begin
        bus.stop_evt <= 1'b1;
        in_frame     <= 1'b0;
        state        <= TSI_IDLE;
        sda_oe       <= 1'b0;
      end
      else
      begin
        case (state)
          TSI_ADDR, TSI_WRITE:
          begin
            if (scl_rise)
            begin
              shift   <= {shift[6:0], sda_sync[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == TSI_BITS_BYTE)
            begin
              if (state == TSI_WRITE)
              begin
                bus.wr_strobe <= 1'b1;
                bus.wr_byte   <= shift;
                sda_oe        <= 1'b1;
                state         <= TSI_ACK_WR;
              end
              else if (shift[7:1] == TSI_SLAVE_ADDR)
              begin
                bus.addr_hit <= 1'b1;
                bus.rw       <= shift[0];
                sda_oe       <= 1'b1;
                state        <= TSI_ACK_ADDR;
              end
              else
              begin
                state <= TSI_IDLE;
              end
            end
          end
          TSI_ACK_ADDR, TSI_ACK_WR, TSI_MACK:
          begin
            if (scl_rise && state == TSI_MACK)
            begin
              master_ack <= ~sda_sync[1];
            end
            if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              if ((state == TSI_ACK_ADDR && bus.rw) ||
                  (state == TSI_MACK && master_ack))
              begin
                // msb leaves first; register file advances on take
                shift       <= bus.rd_data;
                sda_oe      <= ~bus.rd_data[7];
                bus.rd_take <= 1'b1;
                state       <= TSI_READ;
              end
              else if (state == TSI_MACK)
              begin
                // a nack ends the read; wait for stop or restart
                sda_oe <= 1'b0;
                state  <= TSI_IDLE;
              end
              else
              begin
                sda_oe <= 1'b0;
                state  <= TSI_WRITE;
              end
            end
          end
          TSI_READ:
          begin
            if (scl_rise)
            begin
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall)
            begin
              if (bit_cnt == TSI_BITS_BYTE)
              begin
                sda_oe <= 1'b0;
                state  <= TSI_MACK;
              end
              else
              begin
                shift  <= {shift[6:0], 1'b0};
                sda_oe <= ~shift[6];
              end
            end
          end
          default:
          begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// >>> tsi_sensor.sv
// temperature sensor slave: register file, pointer, alerts, bus engine
// assumes temp_value comes from a converter on core_clk; pins are async
`timescale 1ns/10ps
module tsi_sensor
  import tsi_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [15:0] temp_value,
  output logic             int_out,
  output logic             int_oe,
  output logic             crit_out,
  output logic             crit_oe
);

  // ***************************************************************
  // pointer helpers
  // ***************************************************************
  function automatic logic [7:0] next_ptr_of(input logic [7:0] p);
    // only paired registers advance, stopping at TSI_REG_TEMP_LSB and TSI_REG_CRIT_LSB; others hold the pointer
    if (p == TSI_REG_TEMP_MSB ||
        (p >= TSI_REG_HIGH_MSB && p < TSI_REG_CRIT_LSB))
    begin
      next_ptr_of = p + 8'h01;
    end
    else
    begin
      next_ptr_of = p;
    end
  endfunction

  // ***************************************************************
  // bus engine
  // ***************************************************************
  tsi_byte_if bus ();

  tsi_i2c_link u_link
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .bus      (bus.link)
  );

  // ***************************************************************
  // pointer and transaction tracking
  // ***************************************************************
  logic [7:0] ptr;
  logic       expect_ptr;
  logic       ptr_only;
  logic       stale_ptr;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ptr        <= TSI_PTR_RESET;
      expect_ptr <= 1'b0;
      ptr_only   <= 1'b0;
      stale_ptr  <= 1'b0;
    end
    else
    begin
      if (bus.addr_hit)
      begin
        expect_ptr <= ~bus.rw;
        ptr_only   <= 1'b0;
        stale_ptr  <= 1'b0;
        if (bus.rw && stale_ptr && !bus.restart)
        begin
          // pointer write closed by stop, then a fresh read
          ptr <= TSI_PTR_RESET;
        end
      end
      else if (bus.wr_strobe)
      begin
        expect_ptr <= 1'b0;
        if (expect_ptr)
        begin
          ptr      <= bus.wr_byte;
          ptr_only <= 1'b1;
        end
        else
        begin
          ptr      <= next_ptr_of(ptr);
          ptr_only <= 1'b0;
        end
      end
      else if (bus.rd_take)
      begin
        ptr <= next_ptr_of(ptr);
      end
      else if (bus.stop_evt)
      begin
        stale_ptr <= ptr_only;
        ptr_only  <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // register file
  // ***************************************************************
  logic [7:0]  config_reg;
  logic [15:0] high_limit_pair;
  logic [15:0] low_limit_pair;
  logic [15:0] critical_limit_pair;
  logic        data_wr;

  assign data_wr = bus.wr_strobe & ~expect_ptr;

  // limits hold sane defaults so no setup is needed after power-up
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      config_reg          <= TSI_CONFIG_RESET;
      high_limit_pair     <= TSI_HIGH_RESET;
      low_limit_pair      <= TSI_LOW_RESET;
      critical_limit_pair <= TSI_CRIT_RESET;
    end
    else if (data_wr)
    begin
      case (ptr)
        TSI_REG_CONFIG:   config_reg                <= bus.wr_byte;
        TSI_REG_HIGH_MSB: high_limit_pair[15:8]     <= bus.wr_byte;
        TSI_REG_HIGH_LSB: high_limit_pair[7:0]      <= bus.wr_byte;
        TSI_REG_LOW_MSB:  low_limit_pair[15:8]      <= bus.wr_byte;
        TSI_REG_LOW_LSB:  low_limit_pair[7:0]       <= bus.wr_byte;
        TSI_REG_CRIT_MSB: critical_limit_pair[15:8] <= bus.wr_byte;
        TSI_REG_CRIT_LSB: critical_limit_pair[7:0]  <= bus.wr_byte;
        default:          config_reg                <= config_reg;
      endcase
    end
  end

  // ***************************************************************
  // read path
  // ***************************************************************
  logic [7:0] temp_lsb_hold;
  logic [7:0] next_rd_data;

  // low byte is frozen when the high byte goes out, so a pair never tears
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      temp_lsb_hold <= 8'h00;
    end
    else if (bus.rd_take && ptr == TSI_REG_TEMP_MSB)
    begin
      temp_lsb_hold <= temp_value[7:0];
    end
    else if (!bus.rd_take && ptr != TSI_REG_TEMP_LSB)
    begin
      temp_lsb_hold <= temp_value[7:0];
    end
  end

  always_comb
  begin
    case (ptr)
      TSI_REG_TEMP_MSB: next_rd_data = temp_value[15:8];
      TSI_REG_TEMP_LSB: next_rd_data = temp_lsb_hold;
      TSI_REG_CONFIG:   next_rd_data = config_reg;
      TSI_REG_HIGH_MSB: next_rd_data = high_limit_pair[15:8];
      TSI_REG_HIGH_LSB: next_rd_data = high_limit_pair[7:0];
      TSI_REG_LOW_MSB:  next_rd_data = low_limit_pair[15:8];
      TSI_REG_LOW_LSB:  next_rd_data = low_limit_pair[7:0];
      TSI_REG_CRIT_MSB: next_rd_data = critical_limit_pair[15:8];
      TSI_REG_CRIT_LSB: next_rd_data = critical_limit_pair[7:0];
      default:          next_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      bus.rd_data <= 8'h00;
    end
    else
    begin
      bus.rd_data <= next_rd_data;
    end
  end

  // ***************************************************************
  // alert outputs
  // ***************************************************************
  logic win_alert;
  logic crit_alert;
  logic win_level;
  logic crit_level;

  // comparison is signed, matching the value format the host expects
  assign win_alert  = ($signed(temp_value) > $signed(high_limit_pair)) ||
                      ($signed(temp_value) < $signed(low_limit_pair));
  assign crit_alert = $signed(temp_value) > $signed(critical_limit_pair);

  // active level follows the polarity bit; idle level is its inverse
  assign win_level  = win_alert ? config_reg[TSI_CFG_INT_POL]
                                : ~config_reg[TSI_CFG_INT_POL];
  assign crit_level = crit_alert ? config_reg[TSI_CFG_CRIT_POL]
                                 : ~config_reg[TSI_CFG_CRIT_POL];

  // open drain: only a low is driven, a high relies on the pull-up
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      int_out  <= 1'b0;
      int_oe   <= 1'b0;
      crit_out <= 1'b0;
      crit_oe  <= 1'b0;
    end
    else
    begin
      int_out  <= 1'b0;
      int_oe   <= ~win_level;
      crit_out <= 1'b0;
      crit_oe  <= ~crit_level;
    end
  end

endmodule

// >>> tsi_props.sv
// pin-level checker for the temperature sensor slave
// assumes it is bound to tsi_sensor and sees only its ports
`timescale 1ns/10ps
module tsi_props
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic [15:0] temp_value,
  input wire logic        int_out,
  input wire logic        int_oe,
  input wire logic        crit_out,
  input wire logic        crit_oe
);
  // ****************************
  // quiet time since a cause
  // ****************************
  // bus traffic may carry a polarity write, so it counts as a cause
  logic [3:0]  quiet_cnt;
  logic [15:0] temp_q;
  always_ff @(posedge core_clk)
  begin
    temp_q <= temp_value;
    if (sys_rst || !scl_in || temp_value != temp_q)
      quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hF)
      quiet_cnt <= quiet_cnt + 4'h1;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  sequence stop_s;
    scl_in && $rose(sda_in);
  endsequence
  sequence drive_s;
    $rose(scl_in) ##0 sda_oe;
  endsequence
  chk_pins_low:
    assert property (!sda_out && !int_out && !crit_out)
    else $error("open-drain level not low");
  chk_reset_quiet:
    assert property ($fell(sys_rst) |-> !sda_oe && !int_oe && !crit_oe)
    else $error("pin driven right after reset");
  chk_window_cause:
    assert property ($changed(int_oe) |-> quiet_cnt < 4'hC)
    else $error("window alert moved without cause");
  chk_crit_cause:
    assert property ($changed(crit_oe) |-> quiet_cnt < 4'hC)
    else $error("critical alert moved without cause");
  chk_drive_low:
    assert property ($rose(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 2))
    else $error("data driven outside clock low phase");
  chk_bit_hold:
    assert property (drive_s |=> sda_oe [*4])
    else $error("driven bit dropped in high phase");
  chk_answer_wait:
    assert property ($fell(scl_in) |-> $stable(sda_oe) [*2])
    else $error("data changed too soon after clock fall");
  chk_stop_idle:
    assert property (stop_s |=> !sda_oe [*3])
    else $error("data driven after stop");
endmodule

// >>> tsi_master_model.sv
// two-wire bus master model standing in for the controller logic
// assumes a pulled-up data line; clock stands high between frames
`timescale 1ns/10ps
module tsi_master_model
(
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // four clocks per bus phase (320 ns bus clock): the slave needs
  // two to sync the pins and one more to answer before the next edge
  task automatic ph(input logic on_clk, input logic v);
    tick(2);
    if (on_clk)
      scl = v;
    else
      sda_low = v;
  endtask
  // same steps serve a fresh start and a repeated one
  task automatic open_s;
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  task automatic end_p;
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b0);
    tick(3);
  endtask
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, !b);
    ph(1'b1, 1'b1);
    tick(2);
    r = sda;
    ph(1'b1, 1'b0);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic aok);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(!mack, r);
    aok = !r;
  endtask
endmodule

// >>> test_temp_sensor_i2c_access.sv
// self-checking bench for the temperature sensor slave
// assumes the master model owns the bus; alerts are seen as oe levels
`timescale 1ns/10ps
module test_temp_sensor_i2c_access
  import tsi_pkg::*;
;
  logic        core_clk   = 1'b0;
  logic        sys_rst    = 1'b1;
  logic [15:0] temp_value = 16'h0C88;
  logic        scl;
  logic        sda_low;
  logic        sda_out, sda_oe, int_out, int_oe, crit_out, crit_oe;
  logic [15:0] q;
  int          err_count  = 0;
  int          compares   = 0;
  logic [15:0] tv [7]     = '{16'h1234, 16'h1235, 16'h0500, 16'h04FF,
                              16'h4980, 16'h4981, 16'hF000};
  wire         sda        = !(sda_oe || sda_low); // pull-up

  always #20 core_clk = ~core_clk;

  tsi_sensor u_dut
  (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .temp_value(temp_value),
    .int_out(int_out), .int_oe(int_oe), .crit_out(crit_out),
    .crit_oe(crit_oe)
  );
  tsi_master_model u_mst
  (
    .core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low)
  );

  task automatic conclude;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic ak);
    logic [7:0] rx;
    logic       a;
    u_mst.xfer(b, 1'b0, rx, a);
    chk({15'h0, a}, {15'h0, ak});
  endtask
  // n below zero leaves the bus held for a repeated start
  task automatic wr(input logic [7:0] pt, input int n, input logic [15:0] d);
    u_mst.open_s();
    send({TSI_SLAVE_ADDR, 1'b0}, 1'b1);
    send(pt, 1'b1);
    if (n > 0)
      send(d[15:8], 1'b1);
    if (n > 1)
      send(d[7:0], 1'b1);
    if (n >= 0)
      u_mst.end_p();
  endtask
  task automatic rd(output logic [15:0] v);
    logic a;
    u_mst.open_s();
    send({TSI_SLAVE_ADDR, 1'b1}, 1'b1);
    u_mst.xfer(8'hFF, 1'b1, v[15:8], a);
    u_mst.xfer(8'hFF, 1'b0, v[7:0], a);
    u_mst.end_p();
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("[FAIL] %0t run did not finish", $time);
    conclude();
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    u_mst.tick(4);
    rd(q);
    chk(q, 16'h0C88);
    wr(TSI_REG_HIGH_MSB, 2, 16'h1234);
    wr(TSI_REG_HIGH_MSB, -1, 16'h0000);
    rd(q);
    chk(q, 16'h1234);
    wr(TSI_REG_CRIT_MSB, -1, 16'h0000);
    rd(q);
    chk(q, TSI_CRIT_RESET);
    wr(TSI_REG_LOW_MSB, 0, 16'h0000);
    rd(q);
    chk(q, 16'h0C88);
    u_mst.open_s();
    send({7'h4A, 1'b0}, 1'b0);
    u_mst.end_p();
    // second pass turns both alerts to active high
    for (int p = 0; p < 2; p++)
    begin
      if (p == 1)
        wr(TSI_REG_CONFIG, 1, 16'h0300);
      foreach (tv[i])
      begin
        logic signed [15:0] t;
        t = tv[i];
        temp_value = tv[i];
        u_mst.tick(3);
        chk({14'h0, int_oe, crit_oe},
            {14'h0, p[0] ^ (t > 16'sh1234 || t < $signed(TSI_LOW_RESET)),
             p[0] ^ (t > $signed(TSI_CRIT_RESET))});
      end
    end
    conclude();
  end
endmodule

bind tsi_sensor tsi_props u_props
(
  .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .temp_value(temp_value),
  .int_out(int_out), .int_oe(int_oe), .crit_out(crit_out),
  .crit_oe(crit_oe)
);
